// ### scp_consts.svh
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// clock and power-on timeout
`define SCP_MCLK_HZ 25000000
`define SCP_POR_TIME_MS 150
`define SCP_POR_CYCLES (`SCP_POR_TIME_MS * (`SCP_MCLK_HZ / 1000))

// bus register byte offsets
`define SCP_ADDR_STATUS 8'h00
`define SCP_ADDR_CFG 8'h04
`define SCP_ADDR_TXDATA 8'h08
`define SCP_ADDR_RXDATA 8'h0C
`define SCP_ADDR_PRESCALE 8'h10
`define SCP_HSIZE_WORD 3'h2

// serial command codes, upper byte of the 16-bit word
`define SCP_CMD_CONFIG 8'h80
`define SCP_CMD_POWER 8'h82
`define SCP_CMD_RXREAD 8'hB0
`define SCP_CMD_TXWRITE 8'hB8
`define SCP_CMD_SUPPLY 8'hC0
`define SCP_CMD_FIFO 8'hCA
`define SCP_CMD_WAKE 8'hE0

// reset values of the command registers (low bytes), the prescale register and the flags
`define SCP_CFG_POR 8'h08
`define SCP_PWR_POR 8'h08
`define SCP_PRESCALE_POR 16'h0001
`define SCP_FLAGS_POR 16'h8000

// control bit positions
`define SCP_CFG_EL 7
`define SCP_CFG_EF 6
`define SCP_PWR_EB 2
`define SCP_PWR_EW 1

// status word bit positions
`define SCP_ST_POR 15
`define SCP_ST_TXRDY 14
`define SCP_ST_RXLVL 13
`define SCP_ST_OVUN 12
`define SCP_ST_WAKE 11
`define SCP_ST_PIN 10
`define SCP_ST_SUPPLY 9

// synchroniser vector layout and reset value
`define SCP_SYN_W 9
`define SCP_SYN_RST 9'h0A0

`endif

// ### scp_pkg.sv
package scp_pkg;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_SHIFT = 2'b01,
    SP_DONE = 2'b10,
    SP_REJECT = 2'b11
  } scp_sp_state_t;

  typedef enum logic {
    AHB_IDLE = 1'b0,
    AHB_WAIT = 1'b1
  } scp_ahb_state_t;

  typedef struct packed {
    scp_ahb_state_t ahb_st;
    logic [7:0] a_addr;
    logic a_write;
    logic a_word;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [15:0] prescale;
    scp_sp_state_t sp_st;
    logic [15:0] cmd;
    logic [4:0] bitcnt;
    logic [15:0] sdo_sr;
    logic [15:0] snap;
    logic sdo;
    logic sdo_oe;
    logic sck_q;
    logic sel_q;
    logic ext_q;
    logic [7:0] cfg;
    logic [7:0] pwr;
    logic [3:0] fifo_lvl;
    logic [7:0] wake_per;
    logic [4:0] supply_thr;
    logic [7:0] tx_byte;
    logic tx_full;
    logic [15:0] flags;
    logic irq_n;
    logic [21:0] por_cnt;
    logic por_busy;
    logic [15:0] tick_cnt;
    logic [7:0] wake_cnt;
  } scp_state_t;

endpackage

// ### scp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module scp_sync import scp_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scp_sync_t;

  scp_sync_t s;
  scp_sync_t next_s;

  // first stage feeds only the second stage
  always_comb begin
    next_s = s;
    if (ce) begin
      next_s.s1 = d;
      next_s.s2 = s.s1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.s2;
endmodule
`default_nettype wire

// ### scp_rx_buf.sv
`timescale 1ns/100ps
`default_nettype none
module scp_rx_buf import scp_pkg::*; #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic en,
  input wire logic [3:0] level,
  // fill and drain
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] pop_data,
  output logic [4:0] count,
  // events
  output logic level_evt,
  output logic ovf_evt
);
  typedef struct packed {
    logic [DEPTH-1:0] bits;
    logic [4:0] cnt;
  } scp_rxb_t;

  scp_rxb_t s;
  scp_rxb_t next_s;
  logic [4:0] cnt_mid;
  logic room;

  assign room = ({27'h0, s.cnt} + 32'd8) <= DEPTH;

  // oldest bits sit at the top so reads come out msb first
  always_comb begin
    next_s = s;
    cnt_mid = s.cnt;
    level_evt = 1'b0;
    ovf_evt = 1'b0;
    if (ce && en) begin
      if (pop) begin
        next_s.bits = s.bits << 8;
        cnt_mid = (s.cnt >= 5'h08) ? 5'(s.cnt - 5'h08) : 5'h00;
      end
      if (push && !room) begin
        ovf_evt = 1'b1;
      end else if (push) begin
        next_s.bits = next_s.bits | ({push_data, {(DEPTH-8){1'b0}}} >> cnt_mid);
        cnt_mid = 5'(cnt_mid + 5'h08);
        level_evt = (level != 4'h0) && (cnt_mid >= {1'b0, level}) && (s.cnt < {1'b0, level});
      end
      next_s.cnt = cnt_mid;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pop_data = s.bits[DEPTH-1 -: 8];
  assign count = s.cnt;
endmodule
`default_nettype wire

// ### scp_serial_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "scp_consts.svh"
// Functional notes
// - capture input bit on each rising shift clock while select is low
// - select high resets the serial receiver; next frame starts fresh
// - commands and transmit bytes share the serial input, one frame each
// - each word starts with a command code decoded from leading bits
// - words travel msb first and are assembled in that order
// - don't-care bit positions never influence the decoded function
// - power-on reset loads defaults into all command registers
// - serial commands are rejected during the power-on timeout of 150 ms
// - serial output changes on the falling shift clock edge
// - serial output floats while select is high
// - interrupt output low while any source, including power-on, is pending
// - transmit-ready event when the transmit register can take a byte
// - receive level event when the buffer holds the programmed bit count
// - one flag for receive overflow or transmit underrun
// - timer event when the wake-up period expires
// - external event on a low-going pulse of the external pin
// - supply event when supply is below the programmed threshold
// - receive events only while receive buffer mode is enabled
// - transmit events only while the transmit register is enabled
module scp_serial_port import scp_pkg::*; #(
  parameter int POR_CYCLES = `SCP_POR_CYCLES
) (
  // clock, reset, enable
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // serial control pins
  input wire logic SCK,
  input wire logic CHIP_SELECT_N,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  // interrupt and monitored inputs
  output logic IRQ_OUT_N,
  input wire logic EXT_IRQ_IN_N,
  input wire logic [4:0] SUPPLY_LEVEL
);
  localparam logic [21:0] POR_LAST = 22'(POR_CYCLES - 1);
  localparam scp_state_t RST_STATE = '{
    ahb_st: AHB_IDLE,
    sp_st: SP_IDLE,
    hready: 1'b1,
    prescale: `SCP_PRESCALE_POR,
    sel_q: 1'b1,
    ext_q: 1'b1,
    cfg: `SCP_CFG_POR,
    pwr: `SCP_PWR_POR,
    flags: `SCP_FLAGS_POR,
    por_busy: 1'b1,
    default: '0
  };

  scp_state_t s;
  scp_state_t next_s;

  logic [`SCP_SYN_W-1:0] syn;
  logic sck_s;
  logic sel_s;
  logic sdi_s;
  logic ext_s;
  logic [4:0] supply_s;
  logic sck_rise;
  logic sck_fall;
  logic [7:0] rx_data;
  logic [4:0] rx_count;
  logic rx_lvl_evt;
  logic rx_ovf_evt;
  logic rx_push;
  logic rx_pop;
  logic tx_rdy_set;
  logic tx_unf_set;
  logic wake_evt;
  logic [15:0] status_clr;
  logic [15:0] set;
  logic [15:0] word;

  // multi-bit supply code is slow moving, so a plain two-stage pass is enough
  scp_sync #(.W(`SCP_SYN_W), .RST_VAL(`SCP_SYN_RST)) u_sync (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .d({SCK, CHIP_SELECT_N, SDI, EXT_IRQ_IN_N, SUPPLY_LEVEL}),
    .q(syn)
  );

  assign {sck_s, sel_s, sdi_s, ext_s, supply_s} = syn;
  assign sck_rise = sck_s & ~s.sck_q;
  assign sck_fall = ~sck_s & s.sck_q;

  scp_rx_buf #(.DEPTH(16)) u_rx (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .en(s.cfg[`SCP_CFG_EF]),
    .level(s.fifo_lvl),
    .push(rx_push),
    .push_data(HWDATA[7:0]),
    .pop(rx_pop),
    .pop_data(rx_data),
    .count(rx_count),
    .level_evt(rx_lvl_evt),
    .ovf_evt(rx_ovf_evt)
  );

  always_comb begin
    next_s = s;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    tx_rdy_set = 1'b0;
    tx_unf_set = 1'b0;
    wake_evt = 1'b0;
    status_clr = 16'h0000;
    set = 16'h0000;
    word = 16'h0000;
    if (CE) begin
      next_s.sck_q = sck_s;
      next_s.sel_q = sel_s;
      next_s.ext_q = ext_s;
      // power-on timeout
      if (s.por_busy) begin
        if (s.por_cnt == POR_LAST) begin
          next_s.por_busy = 1'b0;
        end else begin
          next_s.por_cnt = 22'(s.por_cnt + 22'h1);
        end
      end
      // bus slave, one wait state so read data comes from a flop
      case (s.ahb_st)
        AHB_IDLE: begin
          next_s.hready = 1'b1;
          if (HSEL && HTRANS[1] && HREADY) begin
            next_s.ahb_st = AHB_WAIT;
            next_s.a_addr = HADDR[7:0];
            next_s.a_write = HWRITE;
            next_s.a_word = (HSIZE == `SCP_HSIZE_WORD) && (HADDR[31:8] == 24'h000000);
            next_s.hready = 1'b0;
          end
        end
        AHB_WAIT: begin
          next_s.ahb_st = AHB_IDLE;
          next_s.hready = 1'b1;
          next_s.hrdata = 32'h00000000;
          if (!s.a_word) begin
            next_s.hrdata = 32'h00000000;
          end else if (s.a_write) begin
            if (s.a_addr == `SCP_ADDR_RXDATA) begin
              rx_push = 1'b1;
            end else if (s.a_addr == `SCP_ADDR_PRESCALE) begin
              next_s.prescale = HWDATA[15:0];
            end
          end else begin
            if (s.a_addr == `SCP_ADDR_STATUS) begin
              next_s.hrdata = {15'h0000, s.por_busy, s.flags};
            end else if (s.a_addr == `SCP_ADDR_CFG) begin
              next_s.hrdata = {s.pwr, s.cfg, s.wake_per, 3'h0, s.supply_thr};
            end else if (s.a_addr == `SCP_ADDR_TXDATA) begin
              next_s.hrdata = {23'h000000, s.tx_full, s.tx_byte};
              if (s.cfg[`SCP_CFG_EL] && s.tx_full) begin
                next_s.tx_full = 1'b0;
                tx_rdy_set = 1'b1;
              end else if (s.cfg[`SCP_CFG_EL]) begin
                tx_unf_set = 1'b1;
              end
            end else if (s.a_addr == `SCP_ADDR_RXDATA) begin
              next_s.hrdata = {23'h000000, rx_count, s.fifo_lvl};
            end else if (s.a_addr == `SCP_ADDR_PRESCALE) begin
              next_s.hrdata = {16'h0000, s.prescale};
            end
          end
        end
        default: begin
          next_s.ahb_st = AHB_IDLE;
        end
      endcase
      // wake-up timer
      if (s.pwr[`SCP_PWR_EW] && (s.wake_per != 8'h00)) begin
        next_s.tick_cnt = 16'(s.tick_cnt + 16'h0001);
        if (s.tick_cnt >= s.prescale) begin
          next_s.tick_cnt = 16'h0000;
          next_s.wake_cnt = 8'(s.wake_cnt + 8'h01);
          if (8'(s.wake_cnt + 8'h01) >= s.wake_per) begin
            next_s.wake_cnt = 8'h00;
            wake_evt = 1'b1;
          end
        end
      end else begin
        next_s.tick_cnt = 16'h0000;
        next_s.wake_cnt = 8'h00;
      end
      // serial receiver and transmitter
      if (sel_s) begin
        next_s.sp_st = SP_IDLE;
        next_s.bitcnt = 5'h00;
        next_s.cmd = 16'h0000;
        next_s.sdo = 1'b0;
        next_s.sdo_oe = 1'b0;
      end else begin
        case (s.sp_st)
          SP_IDLE: begin
            if (s.por_busy) begin
              next_s.sp_st = SP_REJECT;
            end else begin
              next_s.sp_st = SP_SHIFT;
              next_s.snap = s.flags;
              next_s.sdo = s.flags[15];
              next_s.sdo_sr = {s.flags[14:0], 1'b0};
              next_s.sdo_oe = 1'b1;
            end
          end
          SP_SHIFT: begin
            if (sck_rise) begin
              next_s.cmd = {s.cmd[14:0], sdi_s};
              next_s.bitcnt = 5'(s.bitcnt + 5'h01);
              if ((s.bitcnt == 5'h00) && !sdi_s) begin
                status_clr = s.snap;
              end
              if ((s.bitcnt == 5'h07) && ({s.cmd[6:0], sdi_s} == `SCP_CMD_RXREAD) && s.cfg[`SCP_CFG_EF]) begin
                rx_pop = 1'b1;
                next_s.sdo_sr = {rx_data, 8'h00};
              end
              if (s.bitcnt == 5'h0F) begin
                next_s.sp_st = SP_DONE;
                word = {s.cmd[14:0], sdi_s};
              end
            end
            if (sck_fall) begin
              next_s.sdo = s.sdo_sr[15];
              next_s.sdo_sr = {s.sdo_sr[14:0], 1'b0};
            end
          end
          SP_DONE: begin
            if (sck_fall) begin
              next_s.sdo = s.sdo_sr[15];
              next_s.sdo_sr = {s.sdo_sr[14:0], 1'b0};
            end
          end
          default: begin
            next_s.sp_st = SP_REJECT;
          end
        endcase
      end
      // only the code byte and the used fields are looked at
      if (word[15:8] == `SCP_CMD_CONFIG) begin
        next_s.cfg = word[7:0];
      end else if (word[15:8] == `SCP_CMD_POWER) begin
        next_s.pwr = word[7:0];
      end else if (word[15:8] == `SCP_CMD_FIFO) begin
        next_s.fifo_lvl = word[7:4];
      end else if ((word[15:8] == `SCP_CMD_TXWRITE) && s.cfg[`SCP_CFG_EL]) begin
        next_s.tx_byte = word[7:0];
        next_s.tx_full = 1'b1;
      end else if (word[15:8] == `SCP_CMD_WAKE) begin
        next_s.wake_per = word[7:0];
        next_s.wake_cnt = 8'h00;
      end else if (word[15:8] == `SCP_CMD_SUPPLY) begin
        next_s.supply_thr = word[4:0];
      end
      // sticky flags, a new event wins over a status-read clear
      set[`SCP_ST_TXRDY] = tx_rdy_set;
      set[`SCP_ST_RXLVL] = rx_lvl_evt;
      set[`SCP_ST_OVUN] = rx_ovf_evt | tx_unf_set;
      set[`SCP_ST_WAKE] = wake_evt;
      set[`SCP_ST_PIN] = s.ext_q & ~ext_s;
      set[`SCP_ST_SUPPLY] = s.pwr[`SCP_PWR_EB] && (supply_s < s.supply_thr);
      next_s.flags = (s.flags & ~status_clr) | set;
      next_s.irq_n = ~|next_s.flags;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign HRDATA = s.hrdata;
  assign HREADYOUT = s.hready;
  assign HRESP = s.hresp;
  assign SDO = s.sdo;
  assign SDO_OE = s.sdo_oe;
  assign IRQ_OUT_N = s.irq_n;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET || !CE);

  sequence frame_open;
    $fell(sel_s) ##0 (s.sp_st == SP_IDLE);
  endsequence
  sequence open_ok;
    frame_open ##0 !s.por_busy;
  endsequence

  sdo_float_a: assert property (sel_s |=> !SDO_OE) else $error("sdo driven with select high");
  rx_restart_a: assert property (sel_s |=> (s.sp_st == SP_IDLE) && (s.bitcnt == 5'h00)) else $error("no restart");
  por_block_a: assert property ((s.por_busy && s.sp_st == SP_IDLE && !sel_s) |=> (s.sp_st == SP_REJECT) && !SDO_OE)
    else $error("frame accepted during power-on timeout");
  frame_drive_a: assert property (open_ok |=> SDO_OE ##0 (SDO == $past(s.flags[15]))) else $error("frame not opened");
  msb_shift_a: assert property ((sck_rise && s.sp_st == SP_SHIFT && !sel_s) |=> (s.cmd[0] == $past(sdi_s))
    && (s.cmd[15:1] == $past(s.cmd[14:0]))) else $error("bit not shifted in msb first");
  sdo_edge_a: assert property ((SDO_OE && $past(SDO_OE) && $changed(SDO)) |-> $past(sck_fall))
    else $error("sdo changed off a falling edge");
  irq_hold_a: assert property ((|s.flags) |-> !IRQ_OUT_N) else $error("irq released with flag pending");
  irq_free_a: assert property ((s.flags == 16'h0000) |-> IRQ_OUT_N) else $error("irq held with nothing pending");
  ext_catch_a: assert property ((s.ext_q && !ext_s) |=> s.flags[`SCP_ST_PIN] && !IRQ_OUT_N)
    else $error("external edge lost");
  rx_gate_a: assert property (!s.cfg[`SCP_CFG_EF] |-> !rx_lvl_evt && !rx_ovf_evt) else $error("rx event while off");
  tx_gate_a: assert property (!s.cfg[`SCP_CFG_EL] |-> !tx_rdy_set && !tx_unf_set) else $error("tx event while off");

  // every source lands in its sticky flag one edge later
  sequence status_cmd;
    sck_rise && (s.sp_st == SP_SHIFT) && (s.bitcnt == 5'h00) && !sdi_s && !sel_s;
  endsequence

  status_clr_a: assert property (status_cmd ##0 (set == 16'h0000)
    |=> ((s.flags & $past(s.snap)) == 16'h0000)) else $error("status read left flags set");
  rx_level_a: assert property (rx_lvl_evt |=> s.flags[`SCP_ST_RXLVL])
    else $error("level flag not set");
  ovun_flag_a: assert property ((rx_ovf_evt || tx_unf_set) |=> s.flags[`SCP_ST_OVUN])
    else $error("overflow or underrun flag not set");
  tx_ready_a: assert property (tx_rdy_set |=> s.flags[`SCP_ST_TXRDY])
    else $error("ready flag not set");
  wake_flag_a: assert property (wake_evt |=> s.flags[`SCP_ST_WAKE] && !IRQ_OUT_N)
    else $error("wake flag not set");
  supply_flag_a: assert property ((s.pwr[`SCP_PWR_EB] && (supply_s < s.supply_thr))
    |=> s.flags[`SCP_ST_SUPPLY]) else $error("supply flag not set");
  cfg_load_a: assert property ((word[15:8] == `SCP_CMD_CONFIG) |=> (s.cfg == $past(word[7:0])))
    else $error("config word not loaded");
  // one wait state keeps read data coming from a flop
  ahb_wait_a: assert property ((s.ahb_st == AHB_IDLE) && HSEL && HTRANS[1] && HREADY |=> !HREADYOUT ##1 HREADYOUT)
    else $error("bus data phase not two cycles");
endmodule
`default_nettype wire

// ### scp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module scp_host_model (
  // serial pins
  output logic sck = 1'b0,
  output logic cs_n = 1'b1,
  output logic sdi = 1'b0,
  input wire logic sdo,
  input wire logic sdo_oe,
  // frame result
  output logic [15:0] word = 16'h0000,
  output logic done = 1'b0,
  output logic oe_seen = 1'b0
);
  logic last = 1'b0;
  logic line;
  // a released line shows the inverse of its last level, never a stale bit
  always_comb line = sdo_oe ? sdo : ~last;
  always @(sdo or sdo_oe) begin
    if (sdo_oe) last = sdo;
  end
  always @(posedge sdo_oe) oe_seen = 1'b1;
  // shift clock stands still low outside frames
  task automatic frame(input logic [15:0] w);
    oe_seen = 1'b0;
    // start off the bench clock edges so no pin moves on an edge
    #5 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      #160 sck = 1'b1;
      // sample late in the high phase: output moves a few clocks after the fall
      #159 word = {word[14:0], line};
      #1 sck = 1'b0;
    end
    #160 cs_n = 1'b1;
    sdi = ~sdi;
    done = 1'b1;
    #200 done = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### serial_control_port_with_irq_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "scp_consts.svh"
module serial_control_port_with_irq_bench;
  logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, ext_irq_in_n = 1'b1, ce = 1'b1;
  logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] supply = 5'h1F;
  logic [7:0] tb, rb;
  wire logic [31:0] hrdata;
  wire logic [15:0] h_word;
  wire logic hreadyout, hresp, sck, chip_select_n, sdi, sdo, sdo_oe, irq_out_n, h_done, h_oe;
  logic [31:0] exp_rd[$], msk_rd[$];
  logic [15:0] exp_sd[$];
  int err_count = 0, num_checks = 0;

  always #20 mclk = ~mclk;

  scp_serial_port #(.POR_CYCLES(20)) u_scp_serial_port (
    .MCLK(mclk), .RESET(rst), .CE(ce),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .SCK(sck), .CHIP_SELECT_N(chip_select_n), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe),
    .IRQ_OUT_N(irq_out_n), .EXT_IRQ_IN_N(ext_irq_in_n), .SUPPLY_LEVEL(supply)
  );

  scp_host_model u_host (
    .sck(sck), .cs_n(chip_select_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .word(h_word), .done(h_done), .oe_seen(h_oe)
  );

  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] m);
    cmp("hrdata", e & m, hrdata & m);
  endtask
  task automatic chk_sd(input logic [15:0] e);
    cmp("status word", {16'h0000, e}, {16'h0000, h_word});
  endtask
  task automatic chk_pin(input string what, input logic e, input logic g);
    cmp(what, {31'h0, e}, {31'h0, g});
  endtask

  // results come back in request order, so one queue per kind is enough
  always @(posedge mclk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      chk_rd(exp_rd.pop_front(), msk_rd.pop_front());
      chk_pin("hresp", 1'b0, hresp);
    end
  end
  always @(posedge h_done) begin
    if (exp_sd.size() > 0) chk_sd(exp_sd.pop_front());
  end

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= `SCP_HSIZE_WORD;
    if (!wr) begin
      exp_rd.push_back(d);
      msk_rd.push_back(m);
    end
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~d;
    rd_ph <= !wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    ahb(1'b0, a, e, m);
  endtask
  task automatic ser(input logic [15:0] w, input logic [15:0] e, input logic chk);
    if (chk) exp_sd.push_back(e);
    u_host.frame(w);
    @(posedge mclk);
  endtask

  task automatic results;
    if (exp_rd.size() != 0 || exp_sd.size() != 0) err_count++;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    results();
  end

  initial begin
    void'($urandom(32'hB9AB));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(`SCP_ADDR_STATUS, 32'h00018000, 32'hFFFFFFFF);
    chk_pin("irq_out_n", 1'b0, irq_out_n);
    ser(16'h0000, 16'h0000, 1'b0);
    chk_pin("sdo_oe in early frame", 1'b0, h_oe);
    rd(`SCP_ADDR_STATUS, 32'h00008000, 32'hFFFFFFFF);
    rd(`SCP_ADDR_CFG, 32'h08080000, 32'hFFFF0000);
    ser(16'h0000, 16'h8000, 1'b1);
    chk_pin("sdo_oe in frame", 1'b1, h_oe);
    repeat (4) @(posedge mclk);
    chk_pin("irq_out_n", 1'b1, irq_out_n);
    chk_pin("sdo_oe idle", 1'b0, sdo_oe);
    rd(`SCP_ADDR_TXDATA, 32'h00000000, 32'h00000100);
    ahb(1'b1, `SCP_ADDR_RXDATA, $urandom & 32'hFF, 32'h0);
    rd(`SCP_ADDR_STATUS, 32'h00000000, 32'hFFFFFFFF);
    ser(16'h80C0, 16'h0000, 1'b0);
    ser(16'hCA1F, 16'h0000, 1'b0);
    rd(`SCP_ADDR_RXDATA, 32'h00000001, 32'h0000000F);
    rd(`SCP_ADDR_CFG, 32'h00C00000, 32'h00FF0000);
    rb = 8'($urandom);
    ahb(1'b1, `SCP_ADDR_RXDATA, {24'h000000, rb}, 32'h0);
    rd(`SCP_ADDR_STATUS, 32'h00002000, 32'hFFFFFFFF);
    chk_pin("irq_out_n", 1'b0, irq_out_n);
    repeat (11) ahb(1'b1, `SCP_ADDR_RXDATA, $urandom & 32'hFF, 32'h0);
    rd(`SCP_ADDR_STATUS, 32'h00001000, 32'h00001000);
    ser(16'hB000, {8'h30, rb}, 1'b1);
    rd(`SCP_ADDR_RXDATA, 32'h00000081, 32'h000001FF);
    ser(16'h0000, 16'h3000, 1'b1);
    rd(`SCP_ADDR_TXDATA, 32'h00000000, 32'h00000100);
    rd(`SCP_ADDR_STATUS, 32'h00001000, 32'hFFFFFFFF);
    tb = 8'($urandom);
    ser({8'hB8, tb}, 16'h0000, 1'b0);
    rd(`SCP_ADDR_TXDATA, {23'h0, 1'b1, tb}, 32'h000001FF);
    rd(`SCP_ADDR_STATUS, 32'h00005000, 32'hFFFFFFFF);
    ser(16'h0000, 16'h5000, 1'b1);
    ahb(1'b1, `SCP_ADDR_PRESCALE, 32'h00000002, 32'h0);
    rd(`SCP_ADDR_PRESCALE, 32'h00000002, 32'h0000FFFF);
    ser(16'hE003, 16'h0000, 1'b0);
    ser(16'h820A, 16'h0000, 1'b0);
    repeat (100) @(posedge mclk);
    rd(`SCP_ADDR_STATUS, 32'h00000800, 32'h00000800);
    ser(16'h8208, 16'h0000, 1'b0);
    ser(16'h0000, 16'h0800, 1'b1);
    ce <= 1'b0;
    ext_irq_in_n <= 1'b0;
    repeat (3) @(posedge mclk);
    ext_irq_in_n <= 1'b1;
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`SCP_ADDR_STATUS, 32'h00000000, 32'hFFFFFFFF);
    ext_irq_in_n <= 1'b0;
    repeat (3) @(posedge mclk);
    ext_irq_in_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`SCP_ADDR_STATUS, 32'h00000400, 32'hFFFFFFFF);
    ser(16'hC010, 16'h0000, 1'b0);
    ser(16'h820C, 16'h0000, 1'b0);
    supply <= 5'h05;
    repeat (8) @(posedge mclk);
    rd(`SCP_ADDR_STATUS, 32'h00000600, 32'hFFFFFFFF);
    supply <= 5'h1F;
    repeat (4) @(posedge mclk);
    ser(16'h0000, 16'h0600, 1'b1);
    repeat (4) @(posedge mclk);
    chk_pin("irq_out_n", 1'b1, irq_out_n);
    results();
  end
endmodule
`default_nettype wire
